// *** hw/svdc_top.sv ***
// Contract
// - option mode bits pick combined, reset, interrupt
// - combined: irq high, reset low, release high
// - reset mode: one threshold asserts and releases
// - interrupt mode: startup reset, then both-edge irq
// - control bit 0 shows below-threshold while active
// - detector reset sets cause flag bit 0
// - control clears on other resets, kept otherwise
// - control bits 0 and 1 read-only
// - rewrite enable gates level writes, masks outputs
// - combined mode masks during rewrite and settling
// - level register: action bit 7, choice bit 0
// - level reset value follows mode, kept on detector
// - combined mode switches level bits by itself
// - after combined irq both level bits become one
// - option byte group, reserved, level, mode fields
// - detector keeps working in stop state
`timescale 1ns/10ps
`default_nettype none

module svdc_top
	import svdc_pkg::*;
#(
	parameter int SETTLE_CYCLES = SVDC_SETTLE_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [21:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  option_byte,
	input  wire logic        supply_below,
	output logic             threshold_choice_bit,
	output logic             detector_reset,
	output logic             detector_irq
);

	localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYCLES);

	svdc_sync_if #(.W(9)) sif ();

	logic [7:0]   opt;
	svdc_mode_t   mode;
	svdc_state_t  state;
	svdc_state_t  next_state;
	logic [1:0]   init_cnt;
	logic [15:0]  settle_cnt;
	logic         level_rewrite_enable;
	logic         detect_action_bit;
	logic         below_prev;
	logic         detector_reset_cause;

	logic         below_safe;
	logic         lvd_off;
	logic         active;
	logic         below_threshold_flag;
	logic         output_mask_status;
	logic         irq_event;
	logic         rst_event;
	logic         init_done;

	logic         bus_req;
	logic         bus_wr;
	logic         bus_rd;
	logic         sel_ctl;
	logic         sel_lvl;
	logic         sel_opt;
	logic         sel_cause;
	logic         wr_ctl;
	logic         wr_lvl;
	logic [7:0]   next_rdata;
	logic         events_masked;
	logic         choice_write;
	logic         cause_clear;
	svdc_mode_t   init_mode;

	assign sif.raw = {option_byte, supply_below};

	svdc_sync2 #(
		.W (9)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.sif      (sif)
	);

	assign below_safe = sif.safe[0];
	// mode straight from the synchroniser, used before opt is captured
	assign init_mode  = svdc_mode_t'(sif.safe[SVDC_OPT_MODE_MSB + 1:SVDC_OPT_MODE_LSB + 1]);

	assign mode = svdc_mode_t'(opt[SVDC_OPT_MODE_MSB:SVDC_OPT_MODE_LSB]);
	// group msb set with mode lsb set means detector switched off
	assign lvd_off = (mode == SVDC_MODE_OFF)
		|| (opt[SVDC_OPT_GROUP_MSB] && opt[SVDC_OPT_MODE_LSB]);
	assign active = (state != SVDC_ST_INIT) && !lvd_off;
	// wait for the synchroniser to fill before trusting the option
	assign init_done = (state == SVDC_ST_INIT) && (init_cnt == SVDC_INIT_CYCLES);

	assign below_threshold_flag = active && below_safe;

	assign output_mask_status = (mode == SVDC_MODE_COMBINED) && active
		&& (level_rewrite_enable || (settle_cnt != 16'h0000));

	// rewrite enable silences outputs
	// software should set it only in combined mode; gating every mode
	// keeps a stray write from firing a reset in the middle of a rewrite
	assign events_masked = level_rewrite_enable || output_mask_status;

	// detector events, evaluated only while running
	always_comb begin
		irq_event = 1'b0;
		rst_event = 1'b0;
		if (state == SVDC_ST_RUN && active) begin
			case (mode)
				SVDC_MODE_COMBINED: begin
					// irq on high, reset on low
					if (!events_masked && below_safe) begin
						irq_event = !detect_action_bit;
						rst_event = detect_action_bit;
					end
				end
				SVDC_MODE_RESET: begin
					rst_event = below_safe && !events_masked;
				end
				SVDC_MODE_IRQ: begin
					// both crossings interrupt
					// one pulse per crossing, below_prev tracks in every state
					irq_event = (below_safe != below_prev) && !events_masked;
				end
				default: begin
					irq_event = 1'b0;
					rst_event = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			SVDC_ST_INIT: begin
				if (init_done) begin
					next_state = SVDC_ST_HOLD;
				end
			end
			SVDC_ST_HOLD: begin
				// release once at or above threshold
				// startup reset ends at threshold
				// settling must end first so a fresh threshold is trusted
				if (lvd_off) begin
					next_state = SVDC_ST_RUN;
				end else if (!below_safe && settle_cnt == 16'h0000) begin
					next_state = SVDC_ST_RUN;
				end
			end
			SVDC_ST_RUN: begin
				if (rst_event) begin
					next_state = SVDC_ST_HOLD;
				end
			end
			default: begin
				next_state = SVDC_ST_INIT;
			end
		endcase
	end

	// option byte caught once the synchroniser has filled
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state    <= SVDC_ST_INIT;
			init_cnt <= 2'h0;
			opt      <= 8'h00;
		end else begin
			state <= next_state;
			if (state == SVDC_ST_INIT && !init_done) begin
				init_cnt <= init_cnt + 2'h1;
			end
			// option is static, so one capture after the fill is enough
			if (init_done) begin
				opt <= sif.safe[8:1];
			end
		end
	end

	// request follows next_state so it rises as hold is entered
	// no stop-state gating here
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			detector_reset <= 1'b0;
			detector_irq   <= 1'b0;
			below_prev     <= 1'b0;
		end else begin
			detector_reset <= (next_state == SVDC_ST_HOLD) && !lvd_off;
			detector_irq   <= irq_event;
			below_prev     <= below_safe;
		end
	end

	// a software move of the threshold needs settling too, or the
	// comparator swing would read as a crossing
	assign choice_write = wr_lvl && (wb_dat_i[SVDC_LVL_CHOICE] != threshold_choice_bit);

	// combined-mode settling window after an irq, a reset or a level change
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			settle_cnt <= 16'h0000;
		end else if (mode == SVDC_MODE_COMBINED && active
			&& (irq_event || rst_event || choice_write)) begin
			// settle after irq, reset or level change
			settle_cnt <= SETTLE_LOAD;
		end else if (settle_cnt != 16'h0000) begin
			settle_cnt <= settle_cnt - 16'h0001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			detect_action_bit    <= SVDC_LVL_COMBINED[SVDC_LVL_ACTION];
			threshold_choice_bit <= SVDC_LVL_COMBINED[SVDC_LVL_CHOICE];
		end else if (init_done) begin
			case (init_mode)
				SVDC_MODE_RESET: begin
					detect_action_bit    <= SVDC_LVL_RST_ONLY[SVDC_LVL_ACTION];
					threshold_choice_bit <= SVDC_LVL_RST_ONLY[SVDC_LVL_CHOICE];
				end
				SVDC_MODE_IRQ: begin
					detect_action_bit    <= SVDC_LVL_IRQ_ONLY[SVDC_LVL_ACTION];
					threshold_choice_bit <= SVDC_LVL_IRQ_ONLY[SVDC_LVL_CHOICE];
				end
				default: begin
					// off or unlisted codes take the combined image
					detect_action_bit    <= SVDC_LVL_COMBINED[SVDC_LVL_ACTION];
					threshold_choice_bit <= SVDC_LVL_COMBINED[SVDC_LVL_CHOICE];
				end
			endcase
		end else if (mode == SVDC_MODE_COMBINED && irq_event) begin
			detect_action_bit    <= 1'b1;
			threshold_choice_bit <= 1'b1;
		end else if (mode == SVDC_MODE_COMBINED && rst_event) begin
			// back to high threshold for release
			detect_action_bit    <= 1'b1;
			threshold_choice_bit <= 1'b0;
		end else if (wr_lvl) begin
			detect_action_bit    <= wb_dat_i[SVDC_LVL_ACTION];
			threshold_choice_bit <= wb_dat_i[SVDC_LVL_CHOICE];
		end
	end

	// control cleared by non-detector reset only
	// rewrite can be set in every mode, not only combined
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			level_rewrite_enable <= SVDC_CTL_RESET[SVDC_CTL_REWRITE];
		end else if (wr_ctl) begin
			// bits 0 and 1 ignore writes
			level_rewrite_enable <= wb_dat_i[SVDC_CTL_REWRITE];
		end
	end

	// cause flag, set wins over read-clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			detector_reset_cause <= 1'b0;
		end else if (rst_event) begin
			detector_reset_cause <= 1'b1;
		end else if (cause_clear) begin
			detector_reset_cause <= 1'b0;
		end
	end

	// classic wishbone slave, one wait state, every address answered
	// answering unmapped addresses keeps a stray access from hanging
	assign bus_req   = wb_cyc_i && wb_stb_i;
	assign bus_wr    = bus_req && wb_ack_o && wb_we_i;
	assign bus_rd    = bus_req && wb_ack_o && !wb_we_i;
	assign sel_opt   = (wb_adr_i[21:2] == SVDC_IDX_OPTION);
	assign sel_ctl   = (wb_adr_i[21:2] == SVDC_IDX_CONTROL);
	assign sel_lvl   = (wb_adr_i[21:2] == SVDC_IDX_LEVEL);
	assign sel_cause = (wb_adr_i[21:2] == SVDC_IDX_CAUSE);
	assign wr_ctl    = bus_wr && sel_ctl && wb_sel_i[0];
	// level writes blocked without rewrite enable
	assign wr_lvl    = bus_wr && sel_lvl && wb_sel_i[0] && level_rewrite_enable;
	// reading the cause register clears it
	assign cause_clear = bus_rd && sel_cause && wb_sel_i[0];

	always_comb begin
		next_rdata = 8'h00;
		if (sel_opt) begin
			next_rdata = opt;
		end else if (sel_ctl) begin
			next_rdata[SVDC_CTL_REWRITE] = level_rewrite_enable;
			next_rdata[SVDC_CTL_MASK]    = output_mask_status;
			next_rdata[SVDC_CTL_FLAG]    = below_threshold_flag;
		end else if (sel_lvl) begin
			next_rdata[SVDC_LVL_ACTION] = detect_action_bit;
			next_rdata[SVDC_LVL_CHOICE] = threshold_choice_bit;
		end else if (sel_cause) begin
			next_rdata[SVDC_CAUSE_DET] = detector_reset_cause;
		end
	end

	// ack drops the cycle after it was given
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= {24'h000000, next_rdata};
			end
		end
	end

endmodule : svdc_top

`default_nettype wire

// *** hw/svdc_pkg.sv ***
package svdc_pkg;

	// register indices; the bus byte address is four times the index
	localparam logic [19:0] SVDC_IDX_OPTION    = 20'h000C1;
	localparam logic [19:0] SVDC_IDX_CONTROL   = 20'hFFFA9;
	localparam logic [19:0] SVDC_IDX_LEVEL     = 20'hFFFAA;
	localparam logic [19:0] SVDC_IDX_CAUSE     = 20'hFFFAB;

	// voltage_detect_control fields
	localparam int          SVDC_CTL_REWRITE   = 7;
	localparam int          SVDC_CTL_MASK      = 1;
	localparam int          SVDC_CTL_FLAG      = 0;
	localparam logic [7:0]  SVDC_CTL_RESET     = 8'h00;

	// detect_level_select fields and reset values
	localparam int          SVDC_LVL_ACTION    = 7;
	localparam int          SVDC_LVL_CHOICE    = 0;
	localparam logic [7:0]  SVDC_LVL_COMBINED  = 8'h00;
	localparam logic [7:0]  SVDC_LVL_RST_ONLY  = 8'h81;
	localparam logic [7:0]  SVDC_LVL_IRQ_ONLY  = 8'h01;

	// reset_cause_flags fields
	localparam int          SVDC_CAUSE_DET     = 0;

	// supply_monitor_option_byte fields
	localparam int          SVDC_OPT_GROUP_MSB = 7;
	localparam int          SVDC_OPT_GROUP_LSB = 5;
	localparam int          SVDC_OPT_RSVD      = 4;
	localparam int          SVDC_OPT_LEVEL_MSB = 3;
	localparam int          SVDC_OPT_LEVEL_LSB = 2;
	localparam int          SVDC_OPT_MODE_MSB  = 1;
	localparam int          SVDC_OPT_MODE_LSB  = 0;

	// timing
	localparam int          SVDC_CLK_PERIOD_NS = 25;
	localparam int          SVDC_SETTLE_NS     = 10000;
	localparam int          SVDC_SETTLE_CYCLES = (SVDC_SETTLE_NS + SVDC_CLK_PERIOD_NS - 1)
		/ SVDC_CLK_PERIOD_NS;
	localparam logic [1:0]  SVDC_INIT_CYCLES   = 2'h2;

	typedef enum logic [1:0] {
		SVDC_MODE_OFF      = 2'b00,
		SVDC_MODE_IRQ      = 2'b01,
		SVDC_MODE_COMBINED = 2'b10,
		SVDC_MODE_RESET    = 2'b11
	} svdc_mode_t;

	typedef enum logic [1:0] {
		SVDC_ST_INIT = 2'b00,
		SVDC_ST_HOLD = 2'b01,
		SVDC_ST_RUN  = 2'b10
	} svdc_state_t;

endpackage : svdc_pkg

// *** hw/svdc_sync_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface svdc_sync_if #(
	parameter int W = 9
);
	logic [W-1:0] raw;
	logic [W-1:0] safe;

	modport sync (input raw, output safe);
	modport user (output raw, input safe);
endinterface : svdc_sync_if

`default_nettype wire

// *** hw/svdc_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none

module svdc_sync2 #(
	parameter int W = 9
) (
	input  wire logic   core_clk,
	input  wire logic   rst,
	svdc_sync_if.sync   sif
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	// stage1 is read by stage2 only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= sif.raw;
			stage2 <= stage1;
		end
	end

	assign sif.safe = stage2;
endmodule : svdc_sync2

`default_nettype wire

// *** bench/svdc_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module svdc_monitor
	import svdc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [21:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  option_byte,
	input wire logic        supply_below,
	input wire logic        threshold_choice_bit,
	input wire logic        detector_reset,
	input wire logic        detector_irq
);
	logic [1:0] mode;
	logic       rd_ack;

	// off setting folds into mode 0
	assign mode = (option_byte[7] & option_byte[0]) ? 2'h0 : option_byte[1:0];
	assign rd_ack = wb_ack_o & ~wb_we_i;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// two sync stages plus the output register leave one spare cycle
	sequence s_low3;
		(mode == 2'h3 && supply_below) [*3];
	endsequence

	a_irq_pulse: assert property (detector_irq |=> !detector_irq)
		else $error("irq wider than one cycle");
	a_irq_cause: assert property (mode == 2'h2 && $rose(detector_irq) |-> $past(supply_below, 3))
		else $error("combined irq without low supply");
	a_rst_assert: assert property (s_low3 |-> ##2 detector_reset)
		else $error("reset mode missed low supply");
	a_rst_release: assert property (mode[0] && $fell(detector_reset) |-> !$past(supply_below, 3))
		else $error("reset released while below");
	a_no_irq_rst: assert property (mode == 2'h3 |-> !detector_irq)
		else $error("irq in reset mode");
	a_off_quiet: assert property (mode == 2'h0 |-> !(detector_reset || detector_irq))
		else $error("output while detector off");
	a_choice_irq: assert property (mode == 2'h2 && detector_irq |=> threshold_choice_bit)
		else $error("level not lower after irq");
	a_ctl_zero: assert property (rd_ack && wb_adr_i[21:2] == SVDC_IDX_CONTROL |-> wb_dat_o[6:2] == 5'h00)
		else $error("control spare bits not zero");
	a_lvl_zero: assert property (rd_ack && wb_adr_i[21:2] == SVDC_IDX_LEVEL |-> wb_dat_o[6:1] == 6'h00)
		else $error("level spare bits not zero");
endmodule : svdc_monitor

bind svdc_top svdc_monitor u_mon (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .option_byte(option_byte),
	.supply_below(supply_below), .threshold_choice_bit(threshold_choice_bit),
	.detector_reset(detector_reset), .detector_irq(detector_irq));

`default_nettype wire

// *** bench/svdc_supply_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module svdc_supply_model (
	input  wire logic [1:0] level,
	input  wire logic       threshold_choice_bit,
	output logic            supply_below
);
	// level 0 above upper, 1 between thresholds, 2 below lower
	assign supply_below = threshold_choice_bit ? (level == 2'h2) : (level != 2'h0);
endmodule : svdc_supply_model

`default_nettype wire

// *** bench/test_supply_voltage_detector_control.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_supply_voltage_detector_control;
	import svdc_pkg::*;
	logic        core_clk, rst, cyc, stb, we, ack, below, choice, det_rst, irq;
	logic [21:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [7:0]  opt;
	logic [1:0]  lvl;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc_cnt = 0;

	svdc_top #(.SETTLE_CYCLES(20)) uut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .option_byte(opt), .supply_below(below),
		.threshold_choice_bit(choice), .detector_reset(det_rst), .detector_irq(irq));
	svdc_supply_model u_sup (.level(lvl), .threshold_choice_bit(choice), .supply_below(below));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report

	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [19:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'h0};
		wdat <= {24'h000000, d};
		sel <= 4'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) chk(8'h00, 8'h01);
	endtask : bus

	task automatic rd(input logic [19:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk(q, exp);
	endtask : rd

	task automatic wr(input logic [19:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, q);
	endtask : wr

	// wait for reset (k=0) or irq (k=1) to reach v, bounded
	task automatic wt(input logic k, input logic v);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while ((k ? irq : det_rst) !== v && n < 200);
		chk({7'h00, k ? irq : det_rst}, {7'h00, v});
	endtask : wt

	task automatic do_reset(input logic [7:0] o);
		@(posedge core_clk);
		rst <= 1'b1;
		opt <= o;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : do_reset

	task automatic t_reset_vals;
		logic [7:0] op [3];
		logic [7:0] ex [3];
		op = '{8'h1A, 8'h1F, 8'h1D};
		ex = '{8'h00, 8'h81, 8'h01};
		lvl <= 2'h0;
		for (int i = 0; i < 3; i++) begin
			do_reset(op[i]);
			rd(SVDC_IDX_LEVEL, ex[i]);
			rd(SVDC_IDX_CONTROL, 8'h00);
		end
		lvl <= 2'h2;
		do_reset(8'hFF);
		rd(SVDC_IDX_CONTROL, 8'h00);
	endtask : t_reset_vals

	task automatic t_combined;
		lvl <= 2'h0;
		do_reset(8'h1A);
		wt(1'b0, 1'b0);
		lvl <= 2'h1;
		wt(1'b1, 1'b1);
		rd(SVDC_IDX_LEVEL, 8'h81);
		rd(SVDC_IDX_CONTROL, 8'h02);
		repeat (30) @(posedge core_clk);
		lvl <= 2'h2;
		wt(1'b0, 1'b1);
		rd(SVDC_IDX_CAUSE, 8'h01);
		rd(SVDC_IDX_CAUSE, 8'h00);
		rd(SVDC_IDX_LEVEL, 8'h80);
		lvl <= 2'h0;
		wt(1'b0, 1'b0);
		rd(SVDC_IDX_CONTROL, 8'h00);
	endtask : t_combined

	task automatic t_rewrite;
		wr(SVDC_IDX_LEVEL, 8'h01);
		rd(SVDC_IDX_LEVEL, 8'h80);
		wr(SVDC_IDX_CONTROL, 8'h83);
		rd(SVDC_IDX_CONTROL, 8'h82);
		wr(SVDC_IDX_LEVEL, 8'h00);
		rd(SVDC_IDX_LEVEL, 8'h00);
		wr(SVDC_IDX_CONTROL, 8'h00);
		rd(SVDC_IDX_OPTION, 8'h1A);
		rd(20'h00010, 8'h00);
	endtask : t_rewrite

	task automatic t_rst_mode;
		do_reset(8'h1F);
		wt(1'b0, 1'b0);
		lvl <= 2'h2;
		wt(1'b0, 1'b1);
		// between thresholds is above the single one
		lvl <= 2'h1;
		wt(1'b0, 1'b0);
	endtask : t_rst_mode

	task automatic t_irq_mode;
		lvl <= 2'h2;
		do_reset(8'h1D);
		rd(SVDC_IDX_CONTROL, 8'h01);
		wt(1'b0, 1'b1);
		lvl <= 2'h0;
		wt(1'b0, 1'b0);
		lvl <= 2'h2;
		wt(1'b1, 1'b1);
		lvl <= 2'h0;
		wt(1'b1, 1'b1);
	endtask : t_irq_mode

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 22'h000000;
		sel = 4'h1;
		wdat = 32'h00000000;
		opt = 8'h1A;
		lvl = 2'h0;
		t_reset_vals();
		t_combined();
		t_rewrite();
		t_rst_mode();
		t_irq_mode();
		final_report();
	end
endmodule : test_supply_voltage_detector_control

`default_nettype wire
